// *** pkg/rx_front_pkg.sv ***
// constants, state types and the shared prbs_byte function for the receive front end
// assumes one clock; all timing is counted in clock-enabled steps
package rx_front_pkg;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_LOSS = 8'h08;
	localparam logic [7:0] REG_BITS_LO = 8'h0C;
	localparam logic [7:0] REG_BITS_HI = 8'h10;
	localparam logic [7:0] REG_ERRORS = 8'h14;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_SEL_LSB = 1;
	localparam int CTRL_CLR_BIT = 3;
	localparam int ST_FLAGS_LSB = 0;
	localparam int ST_LOSS_BIT = 3;
	localparam int ST_SYNC_BIT = 4;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam logic [1:0] SRC_ADC = 2'h0;
	localparam logic [1:0] SRC_LOOP = 2'h1;
	localparam logic [1:0] SRC_GEN = 2'h2;
	localparam logic [15:0] SRC_UNDEF_WORD = 16'h0000;
	localparam logic [1:0] START_WAIT = 2'h2;
	localparam logic [7:0] ZERO_LIMIT = 8'h3F;
	localparam logic [2:0] LOCK_MATCHES = 3'h3;
	localparam logic [22:0] GEN_SEED = 23'h7FFFFF;

	typedef enum logic [3:0] {CS_IDLE = 4'h1, CS_RESET = 4'h2, CS_WAIT = 4'h4, CS_RUN = 4'h8} ctrl_state_t;
	typedef enum logic [1:0] {SP_HIGH = 2'h1, SP_LOW = 2'h2} split_state_t;
	typedef enum logic [2:0] {SY_IDLE = 3'h1, SY_HUNT = 3'h2, SY_LOCK = 3'h4} sync_state_t;

	// advances the x^23+x^18+1 register by eight bits; returns {state, byte}
	function automatic logic [30:0] prbs_byte(input logic [22:0] s);
		logic [22:0] t;
		logic [7:0] b;
		t = s;
		b = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			b = {b[6:0], t[22] ^ t[17]};
			t = {t[21:0], t[22] ^ t[17]};
		end
		return {t, b};
	endfunction
endpackage

// *** core/byte_checker_core.sv ***
// byte-wide checker for the 2^23-1 sequence: hunt, lock, compare, count
// assumes checker_reset and start come from the same clock domain
`timescale 1ns/1ns
module byte_checker_core
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic byte_rate_en,
	input wire logic checker_reset,
	input wire logic start,
	input wire logic [7:0] byte_in,
	input wire logic flag_clear,
	output logic sm_error,
	output logic synced,
	output logic sync_loss_flag,
	output logic [7:0] sync_loss_count,
	output logic [63:0] bit_count,
	output logic [31:0] error_count
);
	import rx_front_pkg::*;

	sync_state_t state, next_state;
	logic [22:0] lfsr, next_lfsr;
	logic [2:0] match_cnt, next_match_cnt;
	logic [7:0] zero_run_count, next_zero;
	logic [63:0] next_bits;
	logic [31:0] next_errors;
	logic [7:0] next_loss_count;
	logic next_loss, next_sm_error;
	logic [30:0] pred;
	logic step;

	function automatic logic [3:0] ones8(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++)
			n = n + {3'h0, v[i]};
		return n;
	endfunction

	assign pred = prbs_byte(lfsr);
	assign step = byte_rate_en;
	assign synced = (state == SY_LOCK);

	always_comb
	begin
		next_state = state;
		next_lfsr = lfsr;
		next_match_cnt = match_cnt;
		next_zero = zero_run_count;
		next_bits = bit_count;
		next_errors = error_count;
		next_loss_count = sync_loss_count;
		next_loss = sync_loss_flag;
		next_sm_error = sm_error & ~flag_clear;
		if (checker_reset)
		begin
			next_state = SY_IDLE;
			next_match_cnt = 3'h0;
			next_zero = 8'h00;
			next_bits = 64'h0;
			next_errors = 32'h0;
			next_loss_count = 8'h00;
			next_loss = 1'b0;
		end
		else if (step)
		begin
			case (state)
				SY_IDLE:
					if (start)
						next_state = SY_HUNT;
				SY_HUNT:
				begin
					next_lfsr = {lfsr[14:0], byte_in};
					if (pred[7:0] == byte_in && byte_in != 8'h00)
						next_match_cnt = match_cnt + 3'h1;
					else
						next_match_cnt = 3'h0;
					if (next_match_cnt == LOCK_MATCHES)
					begin
						next_state = SY_LOCK;
						next_loss = 1'b0;
					end
					if (!start)
						next_state = SY_IDLE;
				end
				SY_LOCK:
				begin
					next_lfsr = pred[30:8];
					next_bits = bit_count + 64'h8;
					next_errors = error_count + {28'h0, ones8(byte_in ^ pred[7:0])};
					if (byte_in != 8'h00)
						next_zero = 8'h00;
					else if (zero_run_count >= 8'hF8)
						next_zero = 8'hFF;
					else
						next_zero = zero_run_count + 8'h8;
					if (next_zero > ZERO_LIMIT)
					begin
						next_state = SY_HUNT;
						next_loss = 1'b1;
						next_loss_count = sync_loss_count + 8'h1;
						next_match_cnt = 3'h0;
						next_zero = 8'h00;
					end
					if (!start)
						next_state = SY_IDLE;
				end
				default:
				begin
					next_state = SY_IDLE;
					next_sm_error = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= SY_IDLE;
			lfsr <= 23'h0;
			match_cnt <= 3'h0;
			zero_run_count <= 8'h00;
			bit_count <= 64'h0;
			error_count <= 32'h0;
			sync_loss_count <= 8'h00;
			sync_loss_flag <= 1'b0;
			sm_error <= 1'b0;
		end
		else if (ce)
		begin
			state <= next_state;
			lfsr <= next_lfsr;
			match_cnt <= next_match_cnt;
			zero_run_count <= next_zero;
			bit_count <= next_bits;
			error_count <= next_errors;
			sync_loss_count <= next_loss_count;
			sync_loss_flag <= next_loss;
			sm_error <= next_sm_error;
		end
	end

	a_zero_run_loss: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && step && !checker_reset && start && state == SY_LOCK && byte_in == 8'h00 && zero_run_count >= 8'h38)
		|=> state == SY_HUNT && sync_loss_flag)
		else $error("zero run did not drop sync");
	a_counts_kept: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(sync_loss_flag) |-> bit_count == $past(bit_count) + 64'h8)
		else $error("counts lost on sync loss");
	a_bits_step: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && step && !checker_reset && state == SY_LOCK) |=> bit_count == $past(bit_count) + 64'h8)
		else $error("bit count did not advance by eight");
endmodule

// *** core/rx_signal_bert_front.sv ***
// receive front end: source capture, checker control, byte split, stream mux, APB registers
// assumes APB master, sample source and enables all share pclk
`timescale 1ns/1ns
// Overview of operation
// - loopback words feed checker, bypassing ADC registers
// - ADC words pass two register stages
// - own 2^23-1 generator feeds stream output
// - enable first pulses checker reset, clearing counts
// - short wait, then checker start
// - select 01 loopback, 00 ADC, 10 generator
// - one clock; slower rates only by enables
// - byte enable steps the byte checker
// - word enable steps most registers
// - checker error flags forwarded upward
// - three flags mark undefined machine states
// - received data leaves as 16-bit word
// - sync loss flag and 8-bit loss count
// - 64-bit bit count, 32-bit error count
// - flag clear empties sticky error flags
// - words split into two bytes, byte rate
// - over 0x3F zero bits means sync lost
// - resync keeps bit and error counts
module rx_signal_bert_front
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic byte_rate_en,
	input wire logic word_rate_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] adc_word_in,
	input wire logic adc_valid,
	input wire logic [15:0] loopback_word_in,
	output logic [15:0] stream_word_out,
	output logic [2:0] sm_error_flags,
	output logic sync_loss_flag,
	output logic [7:0] sync_loss_count,
	output logic [63:0] bit_count,
	output logic [31:0] error_count
);
	import rx_front_pkg::*;

	// register access
	logic checker_enable, next_enable;
	logic [1:0] rx_source_select, next_select;
	logic flag_clear, next_flag_clear;
	logic [31:0] next_prdata, rd_value;
	logic access, mapped, wr_ctrl;
	logic synced, core_sm_error;

	assign access = psel & penable;
	assign pready = access & ce;
	assign mapped = (paddr == REG_CTRL) || (paddr == REG_STATUS) || (paddr == REG_LOSS)
		|| (paddr == REG_BITS_LO) || (paddr == REG_BITS_HI) || (paddr == REG_ERRORS);
	assign pslverr = access & ~mapped;
	assign wr_ctrl = pready & pwrite & (paddr == REG_CTRL);

	always_comb
	begin
		rd_value = 32'h0;
		case (paddr)
			REG_CTRL: rd_value = {28'h0, 1'b0, rx_source_select, checker_enable};
			REG_STATUS: rd_value = {27'h0, synced, sync_loss_flag, sm_error_flags};
			REG_LOSS: rd_value = {24'h0, sync_loss_count};
			REG_BITS_LO: rd_value = bit_count[31:0];
			REG_BITS_HI: rd_value = bit_count[63:32];
			REG_ERRORS: rd_value = error_count;
			default: rd_value = 32'h0;
		endcase
		next_prdata = prdata;
		if (psel && !penable)
			next_prdata = pwrite ? 32'h0 : rd_value;
		next_enable = checker_enable;
		next_select = rx_source_select;
		next_flag_clear = 1'b0;
		if (wr_ctrl)
		begin
			next_enable = pwdata[CTRL_EN_BIT];
			next_select = pwdata[CTRL_SEL_LSB +: 2];
			next_flag_clear = pwdata[CTRL_CLR_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0;
			checker_enable <= CTRL_RESET[CTRL_EN_BIT];
			rx_source_select <= CTRL_RESET[CTRL_SEL_LSB +: 2];
			flag_clear <= 1'b0;
		end
		else if (ce)
		begin
			prdata <= next_prdata;
			checker_enable <= next_enable;
			rx_source_select <= next_select;
			flag_clear <= next_flag_clear;
		end
	end

	// checker control machine, stepped at word rate
	ctrl_state_t ctrl_state, next_ctrl_state;
	logic [1:0] wait_cnt, next_wait_cnt;
	logic ctrl_error, next_ctrl_error;
	logic checker_reset, checker_start;
	logic word_step;

	assign word_step = ce & word_rate_en;
	assign checker_reset = (ctrl_state == CS_RESET);
	assign checker_start = (ctrl_state == CS_RUN);

	always_comb
	begin
		next_ctrl_state = ctrl_state;
		next_wait_cnt = wait_cnt;
		next_ctrl_error = ctrl_error & ~flag_clear;
		if (word_rate_en)
		begin
			case (ctrl_state)
				CS_IDLE:
					if (checker_enable)
						next_ctrl_state = CS_RESET;
				CS_RESET:
				begin
					next_ctrl_state = CS_WAIT;
					next_wait_cnt = 2'h0;
				end
				CS_WAIT:
					if (wait_cnt == START_WAIT - 2'h1)
						next_ctrl_state = CS_RUN;
					else
						next_wait_cnt = wait_cnt + 2'h1;
				CS_RUN:
					next_ctrl_state = CS_RUN;
				default:
				begin
					next_ctrl_state = CS_IDLE;
					next_ctrl_error = 1'b1;
				end
			endcase
			if (!checker_enable)
				next_ctrl_state = CS_IDLE;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_state <= CS_IDLE;
			wait_cnt <= 2'h0;
			ctrl_error <= 1'b0;
		end
		else if (ce)
		begin
			ctrl_state <= next_ctrl_state;
			wait_cnt <= next_wait_cnt;
			ctrl_error <= next_ctrl_error;
		end
	end

	// word capture, byte split, generator and stream mux
	split_state_t split_state, next_split_state;
	logic split_error, next_split_error;
	logic [15:0] loop_word, next_loop_word;
	logic [15:0] adc_stage1, next_adc_stage1;
	logic [15:0] adc_stage2, next_adc_stage2;
	logic [22:0] gen_lfsr, next_gen_lfsr;
	logic [15:0] gen_word, next_gen_word;
	logic [15:0] next_stream;
	logic [30:0] gen_hi, gen_lo;
	logic [7:0] split_byte;

	assign gen_hi = prbs_byte(gen_lfsr);
	assign gen_lo = prbs_byte(gen_hi[30:8]);
	assign split_byte = (split_state == SP_LOW) ? loop_word[7:0] : loop_word[15:8];

	always_comb
	begin
		next_split_state = split_state;
		next_split_error = split_error & ~flag_clear;
		next_loop_word = loop_word;
		next_adc_stage1 = adc_stage1;
		next_adc_stage2 = adc_stage2;
		next_gen_lfsr = gen_lfsr;
		next_gen_word = gen_word;
		next_stream = stream_word_out;
		if (byte_rate_en)
		begin
			case (split_state)
				SP_HIGH: next_split_state = SP_LOW;
				SP_LOW: next_split_state = SP_HIGH;
				default:
				begin
					next_split_state = SP_HIGH;
					next_split_error = 1'b1;
				end
			endcase
		end
		if (word_rate_en)
		begin
			next_loop_word = loopback_word_in;
			if (split_state == SP_HIGH || split_state == SP_LOW)
				next_split_state = SP_HIGH;
			if (adc_valid)
				next_adc_stage1 = adc_word_in;
			next_adc_stage2 = adc_stage1;
			next_gen_lfsr = gen_lo[30:8];
			next_gen_word = {gen_hi[7:0], gen_lo[7:0]};
			case (rx_source_select)
				SRC_ADC: next_stream = adc_stage2;
				SRC_LOOP: next_stream = loopback_word_in;
				SRC_GEN: next_stream = gen_word;
				default: next_stream = SRC_UNDEF_WORD;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			split_state <= SP_HIGH;
			split_error <= 1'b0;
			loop_word <= 16'h0000;
			adc_stage1 <= 16'h0000;
			adc_stage2 <= 16'h0000;
			gen_lfsr <= GEN_SEED;
			gen_word <= 16'h0000;
			stream_word_out <= 16'h0000;
		end
		else if (ce)
		begin
			split_state <= next_split_state;
			split_error <= next_split_error;
			loop_word <= next_loop_word;
			adc_stage1 <= next_adc_stage1;
			adc_stage2 <= next_adc_stage2;
			gen_lfsr <= next_gen_lfsr;
			gen_word <= next_gen_word;
			stream_word_out <= next_stream;
		end
	end

	byte_checker_core u_core
	(
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.byte_rate_en(byte_rate_en),
		.checker_reset(checker_reset),
		.start(checker_start),
		.byte_in(split_byte),
		.flag_clear(flag_clear),
		.sm_error(core_sm_error),
		.synced(synced),
		.sync_loss_flag(sync_loss_flag),
		.sync_loss_count(sync_loss_count),
		.bit_count(bit_count),
		.error_count(error_count)
	);

	assign sm_error_flags = {core_sm_error, split_error, ctrl_error};

	a_reset_on_enable: assert property (@(posedge pclk) disable iff (!presetn)
		(word_step && ctrl_state == CS_IDLE && checker_enable) |=> checker_reset && !checker_start)
		else $error("enable did not reset the checker first");
	a_start_after_wait: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(checker_start) |-> $past(ctrl_state) == CS_WAIT && $past(wait_cnt) == START_WAIT - 2'h1)
		else $error("checker started without the wait");
	a_mux_loopback: assert property (@(posedge pclk) disable iff (!presetn)
		(word_step && rx_source_select == SRC_LOOP) |=> stream_word_out == $past(loopback_word_in))
		else $error("loopback word not on stream output");
	a_adc_capture: assert property (@(posedge pclk) disable iff (!presetn)
		(word_step && adc_valid) |=> adc_stage1 == $past(adc_word_in))
		else $error("valid adc word not captured");
	a_adc_two_stage: assert property (@(posedge pclk) disable iff (!presetn)
		word_step |=> adc_stage2 == $past(adc_stage1))
		else $error("second adc stage did not follow the first");
	a_mux_adc: assert property (@(posedge pclk) disable iff (!presetn)
		(word_step && rx_source_select == SRC_ADC) |=> stream_word_out == $past(adc_stage2))
		else $error("adc word not on stream output");
	a_mux_undefined: assert property (@(posedge pclk) disable iff (!presetn)
		(word_step && rx_source_select == 2'h3) |=> stream_word_out == SRC_UNDEF_WORD)
		else $error("undefined select drove data");
	a_freeze_on_ce: assert property (@(posedge pclk) disable iff (!presetn)
		!ce |=> $stable(stream_word_out) && $stable(ctrl_state) && $stable(bit_count))
		else $error("state moved with clock enable low");
	a_idle_on_disable: assert property (@(posedge pclk) disable iff (!presetn)
		(word_step && !checker_enable) |=> ctrl_state == CS_IDLE && !checker_start)
		else $error("control did not return to idle");
	a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && flag_clear && !(word_rate_en && !(ctrl_state inside {CS_IDLE, CS_RESET, CS_WAIT, CS_RUN})))
		|=> !ctrl_error)
		else $error("flag clear did not clear the flag");
endmodule

// *** dv/rx_source_model.sv ***
// source model: random adc words with their valid, loopback words of the 2^23-1 sequence
// assumes step is the bench's ce and word enable on pclk
`timescale 1ns/1ns
module rx_source_model
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic step,
	input wire logic zero_mode,
	input wire logic flip_one,
	input wire logic [17:0] rnd,
	output logic [15:0] adc_word_in,
	output logic adc_valid,
	output logic [15:0] loopback_word_in
);
	logic [22:0] lfsr;
	logic [15:0] w;
	logic v;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lfsr = 23'h2A5C31;
			adc_valid <= 1'b0;
			adc_word_in <= 16'h0000;
			loopback_word_in <= 16'h0000;
		end
		else if (step)
		begin
			for (int i = 0; i < 16; i++)
			begin
				w = {w[14:0], lfsr[22] ^ lfsr[17]};
				lfsr = {lfsr[21:0], lfsr[22] ^ lfsr[17]};
			end
			v = rnd[17:16] != 2'h0;
			adc_valid <= v;
			adc_word_in <= v ? rnd[15:0] : ~adc_word_in;
			loopback_word_in <= zero_mode ? 16'h0000 : w ^ {15'h0000, flip_one};
		end
	end
endmodule

// *** dv/rx_signal_bert_front_bench.sv ***
// bench for the receive front end: apb tasks, source model, stream and counter checks
// assumes pclk at 100 MHz and a zero-wait apb slave
`timescale 1ns/1ns
module rx_signal_bert_front_bench;
	import rx_front_pkg::*;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, adc_valid;
	logic sync_loss_flag, zero_mode, flip_one, chk_on;
	logic byte_rate_en = 1'b0;
	logic word_rate_en = 1'b0;
	logic [1:0] ph = 2'h0;
	logic [1:0] cur_sel;
	logic [7:0] paddr, sync_loss_count;
	logic [31:0] pwdata, prdata, error_count, gh;
	logic [15:0] adc_word_in, loopback_word_in, stream_word_out, a1, a2, e, ne;
	logic [2:0] sm_error_flags;
	logic [63:0] bit_count, b0, e0;
	logic [32:0] aq[$];
	logic [17:0] sq[$];
	logic [32:0] r;
	logic [17:0] s;
	logic [1:0] order[4] = '{2'h0, 2'h2, 2'h3, 2'h1};
	logic [17:0] rnd;
	int n_fail = 0;
	int n_compared = 0;
	int gn = 0;
	wire logic step = ce & word_rate_en;

	rx_signal_bert_front dut_u
	(
		.pclk(pclk), .presetn(presetn), .ce(ce), .byte_rate_en(byte_rate_en), .word_rate_en(word_rate_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .adc_word_in(adc_word_in), .adc_valid(adc_valid),
		.loopback_word_in(loopback_word_in), .stream_word_out(stream_word_out),
		.sm_error_flags(sm_error_flags), .sync_loss_flag(sync_loss_flag), .sync_loss_count(sync_loss_count),
		.bit_count(bit_count), .error_count(error_count)
	);
	rx_source_model src_u
	(
		.pclk(pclk), .presetn(presetn), .step(step), .zero_mode(zero_mode), .flip_one(flip_one), .rnd(rnd),
		.adc_word_in(adc_word_in), .adc_valid(adc_valid), .loopback_word_in(loopback_word_in)
	);

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		ph <= ph + 2'h1;
		byte_rate_en <= ph[0];
		word_rate_en <= ph == 2'h3;
	end

	task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
		n_compared++;
		if (got !== ex)
		begin
			n_fail++;
			$display("wrong value %s expected %0h seen %0h", nm, ex, got);
		end
	endtask
	task automatic chk_read(input logic [32:0] ex, input logic [32:0] got);
		chk("apb read", {31'h0, ex}, {31'h0, got});
	endtask
	task automatic chk_word(input string nm, input logic [15:0] ex, input logic [15:0] got);
		chk(nm, {48'h0, ex}, {48'h0, got});
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] ex);
		aq.push_back(ex);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic steps(input int k);
		repeat (k)
		begin
			@(posedge pclk);
			while (step !== 1'b1)
				@(posedge pclk);
		end
	endtask
	task automatic set_ctrl(input logic [3:0] v);
		chk_on <= 1'b0;
		apb(1'b1, REG_CTRL, {28'h0000000, v});
		cur_sel <= v[2:1];
		steps(2);
		gn = 0;
		chk_on <= 1'b1;
	endtask
	function automatic logic [15:0] gnext(input logic [31:0] h);
		logic [47:0] t;
		t = {h, 16'h0000};
		for (int i = 15; i >= 0; i--)
			t[i] = t[i + 23] ^ t[i + 18];
		return t[15:0];
	endfunction
	function automatic logic [63:0] outs();
		return bit_count | {4'h0, stream_word_out, sm_error_flags, sync_loss_flag, sync_loss_count, error_count};
	endfunction
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// notes the select and, except for the generator, the expected stream word at every word step while chk_on is set
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			a1 = 16'h0000;
			a2 = 16'h0000;
		end
		else if (step)
		begin
			case (cur_sel)
				SRC_LOOP: ne = loopback_word_in;
				SRC_ADC: ne = a2;
				SRC_GEN: ne = 16'h0000;
				default: ne = SRC_UNDEF_WORD;
			endcase
			if (chk_on)
				sq.push_back({cur_sel, ne});
			a2 = a1;
			if (adc_valid)
				a1 = adc_word_in;
		end
	end
	// takes the oldest note when a result shows
	always @(negedge pclk)
	begin
		if (psel && penable && !pwrite && pready === 1'b1 && aq.size() > 0)
		begin
			r = aq.pop_front();
			chk_read(r, {pslverr, prdata});
		end
		if (sq.size() > 0)
		begin
			s = sq.pop_front();
			if (s[17:16] != SRC_GEN)
				chk_word("stream word", s[15:0], stream_word_out);
			else
			begin
				if (gn >= 2)
					chk_word("generator word", gnext(gh), stream_word_out);
				gh = {gh[15:0], stream_word_out};
				gn++;
			end
		end
	end

	initial
	begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		results();
	end

	initial
	begin
		void'($urandom(4));
		{presetn, ce, psel, penable, pwrite, zero_mode, flip_one, chk_on} = 8'h40;
		{paddr, pwdata, cur_sel, rnd} = '0;
		// child thread draws from its own stream, seeded from this one
		fork
			forever
			begin
				@(posedge pclk);
				rnd <= 18'($urandom);
			end
		join_none
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("outputs after reset", 64'h0, outs());
		for (int a = 0; a < 32; a += 4)
			rd(8'(a), (a > 20) ? 33'h100000000 : 33'h0);
		apb(1'b1, 8'h40, 32'hFFFFFFFF);
		rd(REG_CTRL, 33'h0);
		for (int i = 0; i < 4; i++)
		begin
			set_ctrl({1'b0, order[i], 1'b1});
			rd(REG_CTRL, {30'h0, order[i], 1'b1});
			steps(12);
		end
		set_ctrl(4'hB);
		rd(REG_CTRL, 33'h3);
		rd(REG_STATUS, 33'h10);
		steps(1);
		b0 = bit_count;
		steps(4);
		chk("bits per four words", b0 + 64'h40, bit_count);
		chk("errors clean", 64'h0, {32'h0, error_count});
		flip_one <= 1'b1;
		steps(1);
		flip_one <= 1'b0;
		steps(4);
		chk("one error", 64'h1, {32'h0, error_count});
		rd(REG_ERRORS, 33'h1);
		zero_mode <= 1'b1;
		steps(10);
		chk("loss flag", 64'h1, {63'h0, sync_loss_flag});
		chk("loss count", 64'h1, {56'h0, sync_loss_count});
		e0 = {32'h0, error_count};
		b0 = bit_count;
		zero_mode <= 1'b0;
		steps(10);
		chk("relock", 64'h0, {63'h0, sync_loss_flag});
		chk("counts kept", 64'h1, {63'h0, bit_count > b0 && error_count >= e0[31:0]});
		rd(REG_LOSS, 33'h1);
		set_ctrl(4'h2);
		set_ctrl(4'h3);
		steps(1);
		chk("cleared counts", 64'h0, bit_count | {32'h0, error_count});
		steps(10);
		chk("restarted", 64'h1, {63'h0, bit_count != 64'h0});
		ce <= 1'b0;
		@(posedge pclk);
		e = stream_word_out;
		b0 = bit_count;
		repeat (8) @(posedge pclk);
		chk("frozen", {b0[47:0], e}, {bit_count[47:0], stream_word_out});
		ce <= 1'b1;
		chk_on <= 1'b0;
		steps(1);
		presetn <= 1'b0;
		@(posedge pclk);
		chk("outputs in reset", 64'h0, outs());
		presetn <= 1'b1;
		steps(12);
		chk("idle after reset", 64'h0, bit_count);
		results();
	end
endmodule
